// [pkg/cvl_pkg.sv]
// constants and types of the counter value capture unit
// assumes a 32-bit axi4-lite register bus and one 200 MHz clock
package cvl_pkg;

    // register byte offsets
    localparam logic [7:0] CVL_CONTROL_OFFSET = 8'h00;
    localparam logic [7:0] CVL_STATUS_OFFSET  = 8'h04;
    localparam logic [7:0] CVL_RESULT1_OFFSET = 8'h08;
    localparam logic [7:0] CVL_RESULT2_OFFSET = 8'h0c;

    // control register field positions
    localparam int CVL_INDEX_EN_BIT    = 0;
    localparam int CVL_EXT_RISE_EN_BIT = 1;
    localparam int CVL_EXT_FALL_EN_BIT = 2;
    localparam int CVL_CMB_RISE_EN_BIT = 3;
    localparam int CVL_CMB_FALL_EN_BIT = 4;
    localparam int CVL_EXT_CONT_BIT    = 5;
    localparam int CVL_CMB_CONT_BIT    = 6;
    localparam int CVL_LOCK_POL_LSB    = 8;
    localparam int CVL_LOCK_POL_W      = 2;

    // status register field positions
    localparam int CVL_INDEX_VALID_BIT = 0;
    localparam int CVL_EXT_VALID_BIT   = 1;
    localparam int CVL_CMB_VALID_BIT   = 2;
    localparam int CVL_EXT_LEVEL_BIT   = 3;
    localparam int CVL_CMB_LEVEL_BIT   = 4;
    localparam int CVL_LOCKED_BIT      = 5;

    // reset values
    localparam logic [31:0] CVL_RESULT_RESET = 32'h0000_0000;
    localparam logic [31:0] CVL_RDATA_RESET  = 32'h0000_0000;

    // axi response codes
    localparam logic [1:0] CVL_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CVL_RESP_SLVERR = 2'h2;

    // pin synchroniser depth and pin index inside the edge bundle
    localparam int CVL_SYNC_STAGES = 3;
    localparam int CVL_PIN_EXT     = 0;
    localparam int CVL_PIN_CMB     = 1;
    localparam int CVL_PIN_COUNT   = 2;

    // count lock polarity on the combined input
    typedef enum logic [1:0] {
        CVL_LOCK_OFF  = 2'b00,
        CVL_LOCK_RISE = 2'b01,
        CVL_LOCK_FALL = 2'b10
    } cvl_lock_type;

endpackage

// [pkg/cvl_edge_if.sv]
// filtered levels and one-cycle edge pulses of the capture pins
// assumes producer and consumer share one clock
`timescale 1ns/100ps
interface cvl_edge_if #(
    parameter int PINS = 2
);
    logic [PINS-1:0] level; // filtered pin level
    logic [PINS-1:0] rise;  // one-cycle rising pulse
    logic [PINS-1:0] fall;  // one-cycle falling pulse

    modport source (output level, rise, fall);
    modport sink   (input  level, rise, fall);
endinterface

// [logic/cvl_edge_sync.sv]
// three-stage pin synchroniser with edge detection, one lane per pin
// assumes asynchronous pins and a synchronous active-high reset
`timescale 1ns/100ps
module cvl_edge_sync
    import cvl_pkg::*;
#(
    parameter int PINS = 2
) (
    input  wire logic            clock,   // system clock
    input  wire logic            rst,     // synchronous reset
    input  wire logic [PINS-1:0] pin,     // raw pins
    cvl_edge_if.source           edges    // levels and pulses
);
    import cvl_pkg::*;

    typedef struct packed {
        logic [PINS-1:0] stage1;
        logic [PINS-1:0] stage2;
        logic [PINS-1:0] stage3;
        logic [PINS-1:0] level;
        logic [PINS-1:0] rise;
        logic [PINS-1:0] fall;
    } cvl_sync_state_type;

    cvl_sync_state_type s;
    cvl_sync_state_type next_s;

    // stage1 feeds only stage2; a change counts when stage2 and
    // stage3 agree, so one pin edge gives at most one pulse
    always_comb begin
        next_s        = s;
        next_s.stage1 = pin;
        next_s.stage2 = s.stage1;
        next_s.stage3 = s.stage2;
        next_s.rise   = '0;
        next_s.fall   = '0;
        for (int i = 0; i < PINS; i++) begin
            if (s.stage2[i] == s.stage3[i] && s.stage3[i] != s.level[i]) begin
                next_s.level[i] = s.stage3[i];          // R23
                next_s.rise[i]  = s.stage3[i];          // R23
                next_s.fall[i]  = ~s.stage3[i];         // R23
            end
        end
    end

    // register the whole lane state
    always_ff @(posedge clock) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign edges.level = s.level;
    assign edges.rise  = s.rise;
    assign edges.fall  = s.fall;

endmodule

// [logic/cvl_capture_unit.sv]
// counter value capture unit with axi4-lite registers
// assumes count and index pulse come from logic on the same clock,
// the two capture pins are asynchronous
// What this block and its host do
// R1 - rising external edge captures into result one
// R2 - falling external edge captures into result one
// R3 - both enables: first external edge either polarity
// R4 - single shot: ignore edges until valid false
// R5 - continuous: every enabled external edge overwrites
// R6 - set external valid after storing
// R7 - external input level readable in status
// R8 - several armed commands: only first taken
// R9 - rearm only after all commands cleared
// R10 - continuous plus index: first event only
// R11 - rising combined edge captures into result two
// R12 - falling combined edge captures into result two
// R13 - both enables: first combined edge either polarity
// R14 - single shot: ignore combined edges until valid false
// R15 - continuous: every enabled combined edge overwrites
// R16 - set combined valid after storing
// R17 - combined input level readable in status
// R18 - lock polarity: capture then block the count
// R19 - index pulse captures once, sets index valid
// R20 - index rearm needs enable and valid false
// R21 - host keeps continuous off for measurement
// R22 - host clears enables before next measurement
// R23 - synchronise pins, one capture per edge
// R24 - capture the count before a same-cycle update
`timescale 1ns/100ps
module cvl_capture_unit
    import cvl_pkg::*;
#(
    parameter int COUNT_W = 32,
    parameter int ADDR_W  = 8
) (
    input  wire logic               clock,          // 200 MHz clock
    input  wire logic               rst,            // synchronous reset
    input  wire logic [COUNT_W-1:0] count_value,    // running count
    input  wire logic               index_pulse,    // index pulse, in domain
    input  wire logic               ext_pin,        // external capture pin
    input  wire logic               cmb_pin,        // combined lock pin
    output logic                    count_lock,     // hold the counter
    input  wire logic [ADDR_W-1:0]  s_axi_awaddr,   // write address
    input  wire logic [2:0]         s_axi_awprot,   // unused protection
    input  wire logic               s_axi_awvalid,  // write address valid
    output logic                    s_axi_awready,  // write address ready
    input  wire logic [31:0]        s_axi_wdata,    // write data
    input  wire logic [3:0]         s_axi_wstrb,    // write byte enables
    input  wire logic               s_axi_wvalid,   // write data valid
    output logic                    s_axi_wready,   // write data ready
    output logic [1:0]              s_axi_bresp,    // write response
    output logic                    s_axi_bvalid,   // write response valid
    input  wire logic               s_axi_bready,   // write response ready
    input  wire logic [ADDR_W-1:0]  s_axi_araddr,   // read address
    input  wire logic [2:0]         s_axi_arprot,   // unused protection
    input  wire logic               s_axi_arvalid,  // read address valid
    output logic                    s_axi_arready,  // read address ready
    output logic [31:0]             s_axi_rdata,    // read data
    output logic [1:0]              s_axi_rresp,    // read response
    output logic                    s_axi_rvalid,   // read data valid
    input  wire logic               s_axi_rready    // read data ready
);
    import cvl_pkg::*;

    typedef struct packed {
        // bus side
        logic               awready;
        logic               wready;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               arready;
        logic               rvalid;
        logic [1:0]         rresp;
        logic [31:0]        rdata;
        logic               aw_held;
        logic               w_held;
        logic [ADDR_W-1:0]  aw_addr;
        logic [31:0]        w_data;
        logic [3:0]         w_strb;
        // control fields written by software
        logic               index_en;
        logic               ext_rise_en;
        logic               ext_fall_en;
        logic               cmb_rise_en;
        logic               cmb_fall_en;
        logic               ext_cont;
        logic               cmb_cont;
        cvl_lock_type       lock_pol;
        // capture state
        logic               index_valid;
        logic               ext_valid;
        logic               cmb_valid;
        logic               first_done;
        logic               cmb_done;
        logic               locked;
        logic [COUNT_W-1:0] result1;
        logic [COUNT_W-1:0] result2;
    } cvl_state_type;

    cvl_state_type s;
    cvl_state_type next_s;

    cvl_edge_if #(.PINS(CVL_PIN_COUNT)) edges ();

    // both capture pins share one synchroniser bank
    cvl_edge_sync #(
        .PINS (CVL_PIN_COUNT)
    ) u_sync (
        .clock (clock),
        .rst   (rst),
        .pin   ({cmb_pin, ext_pin}),
        .edges (edges.source)
    );

    // decoded capture events
    logic ext_event;
    logic cmb_event;
    logic idx_event;
    logic lock_event;
    logic first_armed;
    logic cmb_armed;
    logic [31:0] status_word;
    logic [31:0] control_word;

    // an edge counts only on the polarity that is enabled
    always_comb begin
        ext_event = (s.ext_rise_en && edges.rise[CVL_PIN_EXT])    // R1 R3
                 || (s.ext_fall_en && edges.fall[CVL_PIN_EXT]);   // R2 R3
        cmb_event = (s.cmb_rise_en && edges.rise[CVL_PIN_CMB])    // R11 R13
                 || (s.cmb_fall_en && edges.fall[CVL_PIN_CMB]);   // R12 R13
        idx_event = s.index_en && index_pulse && !s.index_valid;  // R19 R20
        lock_event = (s.lock_pol == CVL_LOCK_RISE && s.cmb_rise_en
                      && edges.rise[CVL_PIN_CMB])                 // R18
                  || (s.lock_pol == CVL_LOCK_FALL && s.cmb_fall_en
                      && edges.fall[CVL_PIN_CMB]);                // R18
        first_armed = s.index_en || s.ext_rise_en || s.ext_fall_en;
        cmb_armed   = s.cmb_rise_en || s.cmb_fall_en;
    end

    // register images seen by the read path
    always_comb begin
        control_word = '0;
        control_word[CVL_INDEX_EN_BIT]    = s.index_en;
        control_word[CVL_EXT_RISE_EN_BIT] = s.ext_rise_en;
        control_word[CVL_EXT_FALL_EN_BIT] = s.ext_fall_en;
        control_word[CVL_CMB_RISE_EN_BIT] = s.cmb_rise_en;
        control_word[CVL_CMB_FALL_EN_BIT] = s.cmb_fall_en;
        control_word[CVL_EXT_CONT_BIT]    = s.ext_cont;
        control_word[CVL_CMB_CONT_BIT]    = s.cmb_cont;
        control_word[CVL_LOCK_POL_LSB +: CVL_LOCK_POL_W] = s.lock_pol;
        status_word = '0;
        status_word[CVL_INDEX_VALID_BIT] = s.index_valid;
        status_word[CVL_EXT_VALID_BIT]   = s.ext_valid;
        status_word[CVL_CMB_VALID_BIT]   = s.cmb_valid;
        status_word[CVL_EXT_LEVEL_BIT]   = edges.level[CVL_PIN_EXT]; // R7
        status_word[CVL_CMB_LEVEL_BIT]   = edges.level[CVL_PIN_CMB]; // R17
        status_word[CVL_LOCKED_BIT]      = s.locked;
    end

    // next state of bus, control and capture logic
    always_comb begin
        next_s = s;

        // write address and data are taken in either order
        if (s_axi_awvalid && s.awready) begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.w_held = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // perform the write once both halves are held
        if (s.aw_held && s.w_held && !s.bvalid) begin
            next_s.aw_held = 1'b0;
            next_s.w_held  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = CVL_RESP_OKAY;
            if (s.aw_addr == ADDR_W'(CVL_CONTROL_OFFSET)) begin
                if (s.w_strb[0]) begin
                    next_s.index_en    = s.w_data[CVL_INDEX_EN_BIT];
                    next_s.ext_rise_en = s.w_data[CVL_EXT_RISE_EN_BIT];
                    next_s.ext_fall_en = s.w_data[CVL_EXT_FALL_EN_BIT];
                    next_s.cmb_rise_en = s.w_data[CVL_CMB_RISE_EN_BIT];
                    next_s.cmb_fall_en = s.w_data[CVL_CMB_FALL_EN_BIT];
                    next_s.ext_cont    = s.w_data[CVL_EXT_CONT_BIT];
                    next_s.cmb_cont    = s.w_data[CVL_CMB_CONT_BIT];
                end
                if (s.w_strb[1]) begin
                    next_s.lock_pol = cvl_lock_type'(
                        s.w_data[CVL_LOCK_POL_LSB +: CVL_LOCK_POL_W]);
                end
            end else if (s.aw_addr == ADDR_W'(CVL_STATUS_OFFSET)
                      || s.aw_addr == ADDR_W'(CVL_RESULT1_OFFSET)
                      || s.aw_addr == ADDR_W'(CVL_RESULT2_OFFSET)) begin
                next_s.bresp = CVL_RESP_OKAY; // read-only, write ignored
            end else begin
                next_s.bresp = CVL_RESP_SLVERR;
            end
        end

        // read path: one read at a time, data sampled at the handshake
        if (s_axi_rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = CVL_RESP_OKAY;
            if (s_axi_araddr == ADDR_W'(CVL_CONTROL_OFFSET)) begin
                next_s.rdata = control_word;
            end else if (s_axi_araddr == ADDR_W'(CVL_STATUS_OFFSET)) begin
                next_s.rdata = status_word;
            end else if (s_axi_araddr == ADDR_W'(CVL_RESULT1_OFFSET)) begin
                next_s.rdata = 32'(s.result1);
            end else if (s_axi_araddr == ADDR_W'(CVL_RESULT2_OFFSET)) begin
                next_s.rdata = 32'(s.result2);
            end else begin
                next_s.rdata = CVL_RDATA_RESET;
                next_s.rresp = CVL_RESP_SLVERR;
            end
        end

        // valid flags fall only with their enables; a capture that
        // lands in the same cycle still sets them, the set wins
        if (!s.ext_rise_en && !s.ext_fall_en) begin
            next_s.ext_valid = 1'b0;                      // R4
        end
        if (!s.index_en) begin
            next_s.index_valid = 1'b0;                    // R20
        end
        if (!first_armed) begin
            next_s.first_done = 1'b0;                     // R9
        end
        if (!cmb_armed) begin
            next_s.cmb_valid = 1'b0;                      // R14
            next_s.cmb_done  = 1'b0;                      // R14
        end

        // first result: only the first armed event is taken, except with external
        // continuous and index off; the external edge wins a tie with the index pulse
        if (!s.first_done) begin                          // R8 R9
            if (ext_event && (s.ext_cont || !s.ext_valid)) begin
                next_s.result1   = count_value;           // R1 R2 R24
                next_s.ext_valid = 1'b1;                  // R6
                // continuous alone keeps going, anything else stops
                if (!s.ext_cont || s.index_en) begin
                    next_s.first_done = 1'b1;             // R4 R10
                end else begin
                    next_s.first_done = 1'b0;             // R5
                end
            end else if (idx_event) begin
                next_s.result1     = count_value;         // R19 R24
                next_s.index_valid = 1'b1;                // R19
                next_s.first_done  = 1'b1;                // R8 R10
            end
        end

        // second result from the combined input
        if (!s.cmb_done && cmb_event
            && (s.cmb_cont || !s.cmb_valid)) begin
            next_s.result2   = count_value;               // R11 R12 R24
            next_s.cmb_valid = 1'b1;                      // R16
            next_s.cmb_done  = !s.cmb_cont;               // R14 R15
        end

        // count lock: capture first, then hold the counter until
        // software drops the polarity or both combined enables
        // polarity code 3 counts as off, like 0
        if ((s.lock_pol != CVL_LOCK_RISE && s.lock_pol != CVL_LOCK_FALL)
            || !cmb_armed) begin
            next_s.locked = 1'b0;                         // R18
        end
        if (lock_event && !s.cmb_done) begin
            next_s.locked = 1'b1;                         // R18
        end

        // each ready only while its own half is not held and its own response is not waiting to drain
        next_s.awready = !next_s.aw_held && !next_s.bvalid;
        next_s.wready  = !next_s.w_held && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;
    end

    // reset leaves every capture disarmed and the bus idle
    always_ff @(posedge clock) begin
        if (rst) begin
            s         <= '0;
            s.awready <= 1'b1;
            s.wready  <= 1'b1;
            s.arready <= 1'b1;
            s.result1 <= COUNT_W'(CVL_RESULT_RESET);
            s.result2 <= COUNT_W'(CVL_RESULT_RESET);
            s.lock_pol <= CVL_LOCK_OFF;
        end else begin
            s <= next_s;
        end
    end

    // all outputs come straight from the state register
    assign count_lock    = s.locked;
    assign s_axi_awready = s.awready;
    assign s_axi_wready  = s.wready;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = s.rdata;
    assign s_axi_rresp   = s.rresp;

endmodule

// [testbench/cvl_capture_chk.sv]
// port assertions for the counter value capture unit
// assumes binding onto cvl_capture_unit, one clock, synchronous reset
`timescale 1ns/100ps
module cvl_capture_chk
    import cvl_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic              clock,         // system clock
    input wire logic              rst,           // synchronous reset
    input wire logic              cmb_pin,       // combined pin
    input wire logic              count_lock,    // counter hold
    input wire logic              s_axi_awvalid, // write address valid
    input wire logic              s_axi_awready, // write address ready
    input wire logic              s_axi_wvalid,  // write data valid
    input wire logic              s_axi_wready,  // write data ready
    input wire logic              s_axi_bvalid,  // write response valid
    input wire logic              s_axi_bready,  // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr,  // read address
    input wire logic              s_axi_arvalid, // read address valid
    input wire logic              s_axi_arready, // read address ready
    input wire logic [31:0]       s_axi_rdata,   // read data
    input wire logic [1:0]        s_axi_rresp,   // read response
    input wire logic              s_axi_rvalid,  // read data valid
    input wire logic              s_axi_rready   // read data ready
);
    logic       cmb_q;
    logic [3:0] since_cmb;

    // cycles since the combined pin moved; a lock needs a recent edge
    always_ff @(posedge clock) begin
        cmb_q <= cmb_pin;
        if (rst) begin
            since_cmb <= 4'hf;
        end else if (cmb_pin != cmb_q) begin
            since_cmb <= 4'h0;
        end else if (since_cmb != 4'hf) begin
            since_cmb <= since_cmb + 4'h1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_lock_cause;
        $rose(count_lock) |-> since_cmb <= 4'h8;
    endproperty
    a_lock_cause: assert property (p_lock_cause)
        else $error("lock without pin edge");
    property p_reset_out;
        $fell(rst) |-> !count_lock && s_axi_awready && s_axi_arready
            && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("bad reset outputs");
    property p_b_once;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_once: assert property (p_b_once)
        else $error("b repeated");
    property p_r_once;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_once: assert property (p_r_once)
        else $error("r repeated");
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block)
        else $error("ar open while r");
    property p_aw_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_aw_block: assert property (p_aw_block)
        else $error("aw open while b");
    property p_wr_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("write response late");
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read data late");
    property p_rd_slverr;
        s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0c
            |=> s_axi_rresp == CVL_RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_rd_slverr: assert property (p_rd_slverr)
        else $error("no slverr");

    c_lock: cover property ($rose(count_lock));
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == CVL_RESP_SLVERR);
endmodule
bind cvl_capture_unit cvl_capture_chk #(.ADDR_W(ADDR_W)) chk (.*);

// [testbench/cvl_sensor_model.sv]
// far-side model: encoder counter that obeys the lock request
// assumes one clock shared with the capture unit
`timescale 1ns/100ps
module cvl_sensor_model (
    input  wire logic        clock,       // system clock
    input  wire logic        rst,         // synchronous reset
    input  wire logic        run,         // count up when high
    input  wire logic        load,        // load a new count
    input  wire logic [31:0] load_value,  // value to load
    input  wire logic        count_lock,  // hold request from the unit
    output logic [31:0]      count_value  // running count
);
    // locked: loads are ignored too
    always_ff @(posedge clock) begin
        if (rst) begin
            count_value <= 32'h0000_0000;
        end else if (!count_lock) begin
            count_value <= load ? load_value : count_value + 32'(run);
        end
    end
endmodule

// [testbench/cvl_capture_unit_test.sv]
// self-checking bench: axi4-lite host, pins, reference model
// assumes the checker is bound from its own file
`timescale 1ns/100ps
module cvl_capture_unit_test;
    import cvl_pkg::*;
    logic        clock, rst, index_pulse, ext_pin, cmb_pin, count_lock;
    logic        run, load, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] load_value, count_value, s_axi_wdata, s_axi_rdata, got;
    logic [31:0] m_ctrl, m_r1, m_r2, cnt;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        m_iv, m_ev, m_cv, m_done, m_lock;
    int          mismatches, comparisons;
    integer      seed;
    logic [31:0] plan[$];

    cvl_capture_unit dut (.*, .s_axi_awprot(3'h0), .s_axi_wstrb(4'hf),
        .s_axi_arprot(3'h0));
    cvl_sensor_model partner (.*);

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic chk(input logic [31:0] g, e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask

    // write: both halves offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        got = s_axi_rdata;
        resp = s_axi_rresp;
    endtask

    task automatic check_all();
        rd(CVL_CONTROL_OFFSET);
        chk(got, m_ctrl);
        rd(CVL_STATUS_OFFSET);
        chk(got, {26'h0, m_lock, cmb_pin, ext_pin, m_cv, m_ev, m_iv});
        rd(CVL_RESULT1_OFFSET);
        chk(got, m_r1);
        rd(CVL_RESULT2_OFFSET);
        chk(got, m_r2);
        chk(count_value, cnt);
    endtask

    // host side: control write plus the model's clearing of flags
    task automatic set_ctrl(input logic [31:0] d);
        wr(CVL_CONTROL_OFFSET, d);
        chk({30'h0, resp}, {30'h0, CVL_RESP_OKAY});
        m_ctrl = d;
        if (d[2:1] == 2'h0) m_ev = 1'b0;
        if (!d[0]) m_iv = 1'b0;
        if (d[2:0] == 3'h0) m_done = 1'b0;
        if (d[4:3] == 2'h0) m_cv = 1'b0;
        if (d[9:8] == 2'h0 || d[9:8] == 2'h3 || d[4:3] == 2'h0) m_lock = 1'b0;
    endtask

    // one event: 0 external pin, 1 combined pin, 2 index pulse
    task automatic fire(input int k);
        logic rise, en;
        if (!m_lock) cnt = $random(seed);
        load_value <= cnt;
        load <= 1'b1;
        @(posedge clock);
        load <= 1'b0;
        repeat (2) @(posedge clock);
        if (k == 2) index_pulse <= 1'b1;
        else if (k == 0) ext_pin <= ~ext_pin;
        else cmb_pin <= ~cmb_pin;
        @(posedge clock);
        index_pulse <= 1'b0;
        repeat (10) @(posedge clock);
        rise = (k == 0) ? ext_pin : cmb_pin;
        if (k == 2 && m_ctrl[0] && !m_done) begin
            m_r1 = cnt;
            m_iv = 1'b1;
            m_done = 1'b1;
        end else if (k == 0) begin
            en = rise ? m_ctrl[1] : m_ctrl[2];
            if (en && (!m_done || (m_ctrl[5] && !m_ctrl[0]))) begin
                m_r1 = cnt;
                m_ev = 1'b1;
                m_done = 1'b1;
            end
        end else if (k == 1) begin
            en = rise ? m_ctrl[3] : m_ctrl[4];
            if (en && (!m_cv || m_ctrl[6])) begin
                m_r2 = cnt;
                m_cv = 1'b1;
                if ((rise && m_ctrl[9:8] == 2'h1)
                    || (!rise && m_ctrl[9:8] == 2'h2)) m_lock = 1'b1;
            end
        end
        check_all();
    endtask

    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watchdog well above the expected run length
    initial begin
        repeat (60000) @(posedge clock);
        mismatches++;
        finish_test();
    end

    initial begin
        seed = 32'hd21e0936;
        {rst, run} = 2'b10;
        {index_pulse, ext_pin, cmb_pin, load, s_axi_awvalid, s_axi_wvalid,
            s_axi_bready, s_axi_arvalid, s_axi_rready} = 9'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, load_value, m_ctrl, m_r1,
            m_r2, cnt, m_iv, m_ev, m_cv, m_done, m_lock} = 213'h0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        check_all();
        rd(8'h10);
        chk({30'h0, resp}, {30'h0, CVL_RESP_SLVERR});
        chk(got, 32'h0);
        wr(CVL_STATUS_OFFSET, 32'hffff_ffff);
        chk({30'h0, resp}, {30'h0, CVL_RESP_OKAY});
        // two rounds of events per control word
        plan = '{32'h02, 0, 32'h04, 0, 32'h06, 0, 32'h08, 0, 32'h10, 0,
            32'h18, 0, 32'h22, 0, 32'h48, 0, 32'h108, 0, 32'h210, 0,
            32'h01, 0, 32'h03, 32'h02, 0, 32'h23, 0};
        plan.push_back(32'h12);
        plan.push_back(32'h0);
        foreach (plan[i]) begin
            set_ctrl(plan[i]);
            repeat (2) begin
                fire(2);
                fire(0);
                fire(1);
            end
        end
        finish_test();
    end
endmodule
